/* File: xlate_pkg.sv */
package xlate_pkg;
  localparam int          ADDR_W          = 7;
  localparam logic [6:0]  SLOT_RST        = 7'h00;
  localparam int          CLK_MHZ         = 100;
  localparam int          BYTE_TO_US      = 1000;
  localparam int          BYTE_TO_CYC     = BYTE_TO_US * CLK_MHZ;
  localparam int          CNT_W           = 24;
  localparam int          BIT_CNT_W       = 4;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  ACK_BIT_IDX     = 4'h8;
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} xfer_state_t;
endpackage

/* File: addr_slot.sv */
`timescale 1ns/10ps
module addr_slot
  import xlate_pkg::*;
#(
  parameter int W = ADDR_W
) (
  input  wire logic [W-1:0] addr_i,    // Incoming 7-bit address
  input  wire logic [W-1:0] source_i,  // Programmed source address
  input  wire logic [W-1:0] target_i,  // Programmed target address
  output logic              hit_o,     // Address equals source
  output logic [W-1:0]      out_o      // Target when hit, else address
);
  always_comb begin
    hit_o = (addr_i == source_i);
    out_o = hit_o ? target_i : addr_i;
  end
endmodule // addr_slot

/* File: i2c_xlate_broadcast.sv */
// How it works
// - Group access by a shared address mapped through translation to the device.
// - Flag shows an acknowledge arrived from the far side last transfer.
// - Flag holds the value of the far side acknowledge bit.
// - Flag sets when the link-side target or controller times out.
// - Matching address is replaced bit by bit by the paired target while forwarding.
// - At most two translation entries, each a source and target pair.
`timescale 1ns/10ps
module i2c_xlate_broadcast
  import xlate_pkg::*;
#(
  parameter int TIMEOUT_CYC = BYTE_TO_CYC
) (
  input  wire logic                sys_clk_i,            // 100 MHz clock
  input  wire logic                sys_rst_i,            // Async reset, high
  input  wire logic [ADDR_W-1:0]   xlate_first_source_i, // First slot source
  input  wire logic [ADDR_W-1:0]   xlate_first_target_i, // First slot target
  input  wire logic [ADDR_W-1:0]   xlate_second_source_i,// Second slot source
  input  wire logic [ADDR_W-1:0]   xlate_second_target_i,// Second slot target
  input  wire logic                control_channel_en_i, // Remote channel on
  input  wire logic                scl_i,                // Host-side SCL
  input  wire logic                sda_i,                // Host-side SDA
  output logic                     sda_o,                // Host-side SDA out
  output logic                     sda_oe_o,             // Host SDA drive
  input  wire logic                far_sda_i,            // Far-side SDA
  output logic                     far_sda_o,            // Far-side SDA out
  output logic                     far_sda_oe_o,         // Far SDA drive
  output logic                     far_scl_o,            // Far-side SCL
  output logic                     far_ack_seen_flag_o,  // Ack arrived
  output logic                     far_ack_value_flag_o, // Ack bit value
  output logic                     timed_out_flag_o      // Link time-out
);
  logic [1:0] scl_s_r, sda_s_r, far_s_r;
  logic       scl_q_r, sda_q_r;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      far_s_r <= 2'h3;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      far_s_r <= {far_s_r[0], far_sda_i};
      scl_q_r <= scl_s_r[1];
      sda_q_r <= sda_s_r[1];
    end
  end
  logic scl, sda, far_sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = scl_s_r[1];
  assign sda      = sda_s_r[1];
  assign far_sda  = far_s_r[1];
  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;
  assign start_c  = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_c   = scl & scl_q_r & ~sda_q_r & sda;

  xfer_state_t           st_r, st_nxt;
  logic [BIT_CNT_W-1:0]  bit_r, bit_nxt;
  logic [ADDR_W-1:0]     shift_r, shift_nxt, xaddr_r, xaddr_nxt;
  logic                  seen_r, seen_nxt, ackv_r, ackv_nxt, to_r, to_nxt;
  logic                  sdo_r, sdo_nxt, sdoe_r, sdoe_nxt, fsdo_r, fsdo_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic                  hit_a, hit_b;
  logic [ADDR_W-1:0]     out_a, out_b, mapped;
  logic [ADDR_W-1:0]     addr_full;
  logic                  mta_r, mta_nxt, mtb_r, mtb_nxt;
  logic [2:0]            idx;

  // Position within the address, most significant bit first.
  assign idx = 3'(ADDR_W - 1) - bit_r[2:0];

  // The address byte is complete once seven bits have been shifted.
  assign addr_full = {shift_r[ADDR_W-2:0], sda};

  addr_slot #(.W(ADDR_W)) u_slot_a (
    .addr_i   (addr_full),
    .source_i (xlate_first_source_i),
    .target_i (xlate_first_target_i),
    .hit_o    (hit_a),
    .out_o    (out_a)
  );
  addr_slot #(.W(ADDR_W)) u_slot_b (
    .addr_i   (addr_full),
    .source_i (xlate_second_source_i),
    .target_i (xlate_second_target_i),
    .hit_o    (hit_b),
    .out_o    (out_b)
  );
  assign mapped = hit_a ? out_a : out_b;

  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    xaddr_nxt = xaddr_r;
    seen_nxt  = seen_r;
    ackv_nxt  = ackv_r;
    to_nxt    = to_r;
    sdo_nxt   = sdo_r;
    sdoe_nxt  = sdoe_r;
    fsdo_nxt  = fsdo_r;
    cnt_nxt   = cnt_r;
    mta_nxt   = mta_r;
    mtb_nxt   = mtb_r;
    if (!control_channel_en_i) begin
      st_nxt   = ST_IDLE;
      sdoe_nxt = 1'b0;
      fsdo_nxt = 1'b1;
    end else if (start_c) begin
      st_nxt    = ST_ADDR;
      bit_nxt   = '0;
      seen_nxt  = 1'b0;
      ackv_nxt  = 1'b1;
      fsdo_nxt  = 1'b0;
      sdoe_nxt  = 1'b0;
      cnt_nxt   = '0;
      mta_nxt   = 1'b1;
      mtb_nxt   = 1'b1;
    end else if (stop_c) begin
      st_nxt   = ST_IDLE;
      fsdo_nxt = 1'b1;
      sdoe_nxt = 1'b0;
    end else if (st_r != ST_IDLE) begin
      if (scl_rise || scl_fall) begin
        cnt_nxt = '0;
      end else if (cnt_r == CNT_W'(TIMEOUT_CYC - 1)) begin
        to_nxt   = 1'b1;
        st_nxt   = ST_IDLE;
        sdoe_nxt = 1'b0;
        fsdo_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
      if (scl_rise) begin
        bit_nxt = (bit_r == ACK_BIT_IDX) ? '0 : bit_r + 1'b1;
        if (bit_r == ACK_BIT_IDX) begin
          st_nxt   = ST_DATA;
          seen_nxt = 1'b1;
          ackv_nxt = far_sda;
        end else if (st_r == ST_ADDR && bit_r < BIT_CNT_W'(ADDR_W)) begin
          shift_nxt = addr_full;
          mta_nxt   = mta_r & (sda == xlate_first_source_i[idx]);
          mtb_nxt   = mtb_r & (sda == xlate_second_source_i[idx]);
          if (bit_r == BIT_CNT_W'(ADDR_W - 1)) begin
            xaddr_nxt = mapped;
          end
        end
      end else if (!scl) begin
        // Far data changes only while the clock is low, so no false start or stop.
        if (bit_r == ACK_BIT_IDX) begin
          sdoe_nxt = ~far_sda;
          sdo_nxt  = 1'b0;
          fsdo_nxt = 1'b1;
        end else if (st_r == ST_ADDR && bit_r < BIT_CNT_W'(ADDR_W)) begin
          // steer address bits
          // The host clock cannot be stretched, so each address bit is steered
          // while it arrives; sources that share a long prefix can mis-steer.
          sdoe_nxt = 1'b0;
          if (mta_r && sda == xlate_first_source_i[idx]) begin
            fsdo_nxt = xlate_first_target_i[idx];
          end else if (mtb_r && sda == xlate_second_source_i[idx]) begin
            fsdo_nxt = xlate_second_target_i[idx];
          end else begin
            fsdo_nxt = sda;
          end
        end else begin
          sdoe_nxt = 1'b0;
          fsdo_nxt = sda;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r    <= ST_IDLE;
      bit_r   <= '0;
      shift_r <= SLOT_RST;
      xaddr_r <= SLOT_RST;
      seen_r  <= 1'b0;
      ackv_r  <= 1'b1;
      to_r    <= 1'b0;
      sdo_r   <= 1'b1;
      sdoe_r  <= 1'b0;
      fsdo_r  <= 1'b1;
      cnt_r   <= '0;
      mta_r   <= 1'b0;
      mtb_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      xaddr_r <= xaddr_nxt;
      seen_r  <= seen_nxt;
      ackv_r  <= ackv_nxt;
      to_r    <= to_nxt;
      sdo_r   <= sdo_nxt;
      sdoe_r  <= sdoe_nxt;
      fsdo_r  <= fsdo_nxt;
      cnt_r   <= cnt_nxt;
      mta_r   <= mta_nxt;
      mtb_r   <= mtb_nxt;
    end
  end

  // The far-side clock follows the host clock once it is synchronised.
  assign far_scl_o            = scl;
  assign sda_o                = sdo_r;
  assign sda_oe_o             = sdoe_r;
  assign far_sda_o            = fsdo_r;
  assign far_sda_oe_o         = ~fsdo_r;
  assign far_ack_seen_flag_o  = seen_r;
  assign far_ack_value_flag_o = ackv_r;
  assign timed_out_flag_o     = to_r;

  a_ack_seen_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && st_r != ST_IDLE && !start_c && !stop_c && scl_rise
     && bit_r == ACK_BIT_IDX) |=> seen_r)
    else $error("ack seen flag not set");
  a_ack_value_cap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && st_r != ST_IDLE && !start_c && !stop_c && scl_rise
     && bit_r == ACK_BIT_IDX) |=> ackv_r == $past(far_sda))
    else $error("ack value flag wrong");
  a_timeout_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    to_r |=> to_r)
    else $error("timeout flag dropped");
  a_xlate_map: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && st_r == ST_ADDR && !start_c && !stop_c && scl_rise
     && bit_r == BIT_CNT_W'(ADDR_W - 1) && hit_a) |=> xaddr_r == $past(xlate_first_target_i))
    else $error("address not translated");
  a_xlate_second: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && st_r == ST_ADDR && !start_c && !stop_c && scl_rise
     && bit_r == BIT_CNT_W'(ADDR_W - 1) && !hit_a && hit_b)
    |=> xaddr_r == $past(xlate_second_target_i))
    else $error("second slot not applied");
  a_xlate_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && st_r == ST_ADDR && !start_c && !stop_c && scl_rise
     && bit_r == BIT_CNT_W'(ADDR_W - 1) && !hit_a && !hit_b) |=> xaddr_r == $past(addr_full))
    else $error("unmatched address changed");
  a_seen_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (control_channel_en_i && start_c) |=> !seen_r && ackv_r)
    else $error("flags not cleared at start");
  a_chan_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !control_channel_en_i |=> st_r == ST_IDLE && far_sda_o)
    else $error("disabled channel not idle");
endmodule // i2c_xlate_broadcast

/* File: far_i2c_target.sv */
`timescale 1ns/10ps
module far_i2c_target #(
  parameter logic [6:0] DEV = 7'h00
) (
  input  wire logic scl_i,  // Far-side clock
  input  wire logic sda_i,  // Resolved far-side data line
  output logic      pull_o  // High while pulling data low
);
  int         bit_n = 0;
  logic [7:0] sh    = 8'h00;
  logic       first = 1'b0;
  logic       sel   = 1'b0;
  initial pull_o = 1'b0;
  // A start restarts the byte count, so a stale selection cannot carry over.
  always @(negedge sda_i) if (scl_i) begin
    bit_n = 0;
    first = 1'b1;
    sel   = 1'b0;
    pull_o <= 1'b0;
  end
  always @(posedge scl_i) begin
    if (bit_n < 8) sh = {sh[6:0], sda_i};
    bit_n++;
  end
  // wired acknowledge
  // Acknowledge is a pull low; another target pulling masks ours.
  always @(negedge scl_i) begin
    if (bit_n == 8) begin
      if (first) sel = (sh[7:1] == DEV);
      pull_o <= sel;
    end else if (bit_n == 9) begin
      pull_o <= 1'b0;
      bit_n = 0;
      first = 1'b0;
    end
  end
endmodule // far_i2c_target

/* File: i2c_xlate_broadcast_tb.sv */
`timescale 1ns/10ps
module i2c_xlate_broadcast_tb;
  import xlate_pkg::*;
  localparam logic [6:0] SER = 7'h42, SEN = 7'h36, BC = 7'h62, VS = 7'h10;
  logic sys_clk_i, sys_rst_i, scl, sda, en;
  logic sda_o, sda_oe_o, far_sda_o, far_sda_oe_o, far_scl_o, seen, val, tmo, p1, p2;
  wire  far_line = ~((far_sda_oe_o & ~far_sda_o) | p1 | p2);
  wire  host_line = sda & ~(sda_oe_o & ~sda_o);
  int   n_mismatch = 0;
  int   num_checks = 0;
  int   addr_q[$] = '{BC, VS, SER, SEN, 7'h55};
  i2c_xlate_broadcast #(.TIMEOUT_CYC(200)) uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .xlate_first_source_i(BC), .xlate_first_target_i(SER),
    .xlate_second_source_i(VS), .xlate_second_target_i(SEN),
    .control_channel_en_i(en), .scl_i(scl), .sda_i(host_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .far_sda_i(far_line),
    .far_sda_o(far_sda_o), .far_sda_oe_o(far_sda_oe_o), .far_scl_o(far_scl_o),
    .far_ack_seen_flag_o(seen), .far_ack_value_flag_o(val), .timed_out_flag_o(tmo));
  far_i2c_target #(.DEV(SER)) ser_m (.scl_i(far_scl_o), .sda_i(far_line), .pull_o(p1));
  far_i2c_target #(.DEV(SEN)) sen_m (.scl_i(far_scl_o), .sda_i(far_line), .pull_o(p2));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reference model: first slot wins, then second, else the address passes.
  function automatic logic acked(input logic [6:0] a);
    logic [6:0] d;
    d = (a == BC) ? SER : (a == VS) ? SEN : a;
    return (d == SER) || (d == SEN);
  endfunction
  // SCL low 5 and high 8 cycles, one 130 ns link clock period.
  task automatic bitx(input logic b);
    sda <= b;
    cyc(4);
    scl <= 1'b1;
    cyc(8);
    scl <= 1'b0;
    cyc(1);
  endtask
  task automatic start_bus;
    sda <= 1'b1;
    scl <= 1'b1;
    cyc(4);
    sda <= 1'b0;
    cyc(4);
    scl <= 1'b0;
    cyc(2);
  endtask
  task automatic stop_bus;
    sda <= 1'b0;
    cyc(4);
    scl <= 1'b1;
    cyc(4);
    sda <= 1'b1;
    cyc(8);
  endtask
  // Write transfer: address, write bit, ack slot, one data byte, ack slot.
  task automatic xfer(input logic [6:0] a, input logic [7:0] d);
    start_bus();
    for (int i = 6; i >= 0; i--) bitx(a[i]);
    bitx(1'b0);
    bitx(1'b1);
    for (int i = 7; i >= 0; i--) bitx(d[i]);
    bitx(1'b1);
    stop_bus();
  endtask
  task automatic xcheck(input logic [6:0] a);
    xfer(a, 8'($urandom));
    chk(seen, 1'b1);
    chk(val, ~acked(a));
  endtask
  initial begin
    #300us;
    n_mismatch++;
    end_sim();
  end
  initial begin
    sys_rst_i = 1'b1;
    scl = 1'b1;
    sda = 1'b1;
    en = 1'b1;
    void'($urandom(32'h45d7fef2));
    cyc(5);
    chk(seen, 1'b0);
    chk(val, 1'b1);
    chk(tmo, 1'b0);
    sys_rst_i <= 1'b0;
    cyc(4);
    // translation table
    // Broadcast, virtual, pass-through and unclaimed addresses in turn.
    foreach (addr_q[i]) xcheck(7'(addr_q[i]));
    repeat (10) xcheck(7'(addr_q[$urandom_range(4)]));
    xcheck(7'h55);
    en <= 1'b0;
    cyc(1);
    xfer(SER, 8'h5a);
    chk(val, 1'b1);
    en <= 1'b1;
    cyc(4);
    chk(tmo, 1'b0);
    start_bus();
    cyc(300);
    chk(tmo, 1'b1);
    stop_bus();
    xcheck(BC);
    chk(tmo, 1'b1);
    end_sim();
  end
endmodule // i2c_xlate_broadcast_tb
